/* hdl/csp_pkg.sv */
// Package with register map, field positions and types for the clocked serial port.
package csp_pkg;
  // ****************************************************************
  // Register map (block base address and word indices)
  // ****************************************************************
  localparam logic [15:0] CSP_BUS_CONTROL_OFF = 16'hFF61;
  localparam logic [3:0] CSP_IDX_MODE = 4'h0;
  localparam logic [3:0] CSP_IDX_SHIFT = 4'h1;
  localparam logic [3:0] CSP_IDX_BUS_CTRL = 4'h2;
  localparam logic [3:0] CSP_IDX_STATUS = 4'h3;
  localparam logic [7:0] CSP_BUS_CTRL_RESET = 8'h00;
  localparam logic [7:0] CSP_MODE_RESET = 8'h00;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CSP_RELEASE_BIT = 0;
  localparam int CSP_COMMAND_BIT = 1;
  localparam int CSP_ORDER_BIT = 2;
  localparam int CSP_INTCLK_BIT = 3;
  localparam int CSP_TWO_WIRE_BIT = 4;
  localparam int CSP_ENABLE_BIT = 7;
  localparam int CSP_ST_DONE_BIT = 0;
  localparam int CSP_ST_BUSY_BIT = 1;
  localparam int CSP_UNIT_BITS = 8;
  localparam int CSP_DIV_DEFAULT = 4;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } csp_word_t;
  typedef struct packed {
    logic clk_out;
    logic clk_oe_n;
    logic data_out;
    logic data_oe_n;
  } csp_pins_t;
endpackage

/* hdl/csp_port.sv */
// Top of the clocked three-wire serial port with Wishbone register access.
`timescale 1ns/1ps
module csp_port
  import csp_pkg::*;
#(
  parameter int DIV = CSP_DIV_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic LINK_CLK,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [15:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SERIAL_INPUT_PIN,
  input wire logic SHARED_DATA_IN,
  output logic SERIAL_OUTPUT_LATCH,
  output logic SHARED_DATA_OE_N,
  output logic SERIAL_CLOCK_OUT,
  output logic SERIAL_CLOCK_OE_N,
  output logic TRANSFER_DONE
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] bit_rev(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    return r;
  endfunction
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic ack_ff;
  logic [7:0] mode_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] shreg_ff;
  logic latch_ff;
  logic clk_latch_ff;
  logic done_ff;
  logic busy_ff;
  logic start_tgl_ff;
  logic d1_ff;
  logic d2_ff;
  logic d3_ff;
  logic d4_ff;
  logic [7:0] rxs1_ff;
  logic [7:0] rxs2_ff;
  logic sck_ff;
  logic [7:0] div_ff;
  logic [3:0] edge_cnt_ff;
  logic sout_link;
  logic [7:0] rx_link;
  logic done_tgl_link;
  // ****************************************************************
  // Wishbone decode
  // ****************************************************************
  wire req = WB_CYC_I && WB_STB_I && !ack_ff;
  wire base_hit = WB_ADR_I[15:6] == CSP_BUS_CONTROL_OFF[15:6];
  wire [3:0] idx = WB_ADR_I[5:2];
  wire wr = req && WB_WE_I && WB_SEL_I[0] && base_hit;
  wire wr_mode = wr && idx == CSP_IDX_MODE;
  wire wr_shift = wr && idx == CSP_IDX_SHIFT;
  wire wr_ctrl = wr && idx == CSP_IDX_BUS_CTRL;
  wire rd_shift = req && !WB_WE_I && base_hit && idx == CSP_IDX_SHIFT;
  wire enable = mode_ff[CSP_ENABLE_BIT];
  wire lsb_first = mode_ff[CSP_ORDER_BIT];
  wire two_wire = mode_ff[CSP_TWO_WIRE_BIT];
  wire int_clk = mode_ff[CSP_INTCLK_BIT];
  // One stage late so the received byte has settled through both of its flops
  wire done_evt = d3_ff ^ d4_ff;
  // Start needs enable already set; writes to a disabled port only store data
  wire can_start = enable && !busy_ff;
  wire start = wr_shift && can_start;
  wire [7:0] wr_data = lsb_first ? bit_rev(WB_DAT_I[7:0]) : WB_DAT_I[7:0];
  wire [7:0] rd_data_shift = lsb_first ? bit_rev(shreg_ff) : shreg_ff;
  // Trigger bits read as zero: they clear right after acting
  wire [7:0] ctrl_rd = {ctrl_ff[7:2], 2'b00};
  wire [7:0] status_rd = {6'h00, busy_ff, done_ff};
  wire [7:0] rd_mux = !base_hit ? 8'h00 :
    idx == CSP_IDX_MODE ? mode_ff :
    idx == CSP_IDX_SHIFT ? rd_data_shift :
    idx == CSP_IDX_BUS_CTRL ? ctrl_rd :
    idx == CSP_IDX_STATUS ? status_rd : 8'h00;
  // ****************************************************************
  // Bus answer
  // ****************************************************************
  // One-wait-state ack; unmapped reads return zero, writes are dropped
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ack_ff <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      WB_DAT_O <= req ? {24'h000000, rd_mux} : 32'h0000_0000;
    end
  end
  assign WB_ACK_O = ack_ff;
  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Latch write: release sets, command clears, then triggers vanish
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      mode_ff <= CSP_MODE_RESET;
      ctrl_ff <= CSP_BUS_CTRL_RESET;
      latch_ff <= 1'b1;
      clk_latch_ff <= 1'b1;
    end else begin
      if (wr_mode) begin
        mode_ff <= WB_DAT_I[7:0];
        clk_latch_ff <= WB_DAT_I[5];
      end
      if (wr_ctrl && enable) begin
        ctrl_ff <= {WB_DAT_I[7:2], 2'b00};
        if (WB_DAT_I[CSP_RELEASE_BIT]) begin
          latch_ff <= 1'b1;
        end else if (WB_DAT_I[CSP_COMMAND_BIT]) begin
          latch_ff <= 1'b0;
        end
      end else if (!enable) begin
        ctrl_ff <= {ctrl_ff[7:2], 2'b00};
      end
    end
  end
  // ****************************************************************
  // Shift data and status
  // ****************************************************************
  // Done flag: completion beats a same-cycle read-clear
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      shreg_ff <= 8'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      start_tgl_ff <= 1'b0;
      d1_ff <= 1'b0;
      d2_ff <= 1'b0;
      d3_ff <= 1'b0;
      d4_ff <= 1'b0;
      rxs1_ff <= 8'h00;
      rxs2_ff <= 8'h00;
    end else begin
      d1_ff <= done_tgl_link;
      d2_ff <= d1_ff;
      d3_ff <= d2_ff;
      d4_ff <= d3_ff;
      rxs1_ff <= rx_link;
      rxs2_ff <= rxs1_ff;
      if (wr_shift && !busy_ff) begin
        shreg_ff <= wr_data;
      end else if (done_evt) begin
        shreg_ff <= rxs2_ff;
      end
      if (start) begin
        busy_ff <= 1'b1;
        start_tgl_ff <= ~start_tgl_ff;
      end else if (done_evt) begin
        busy_ff <= 1'b0;
      end
      if (done_evt) begin
        done_ff <= 1'b1;
      end else if (rd_shift || start) begin
        done_ff <= 1'b0;
      end
    end
  end
  // ****************************************************************
  // Internal serial clock
  // ****************************************************************
  // Runs only during a transfer; idles at the clock latch level taken from mode bit 5
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sck_ff <= 1'b1;
      div_ff <= 8'h00;
      edge_cnt_ff <= 4'h0;
    end else if (start) begin
      sck_ff <= 1'b1;
      div_ff <= 8'h00;
      edge_cnt_ff <= 4'h0;
    end else if (busy_ff && edge_cnt_ff != 4'hF) begin
      if (div_ff == 8'(DIV - 1)) begin
        div_ff <= 8'h00;
        sck_ff <= ~sck_ff;
        edge_cnt_ff <= edge_cnt_ff + 4'h1;
      end else begin
        div_ff <= div_ff + 8'h01;
      end
    end else begin
      sck_ff <= clk_latch_ff;
    end
  end
  // ****************************************************************
  // Link engine and pins
  // ****************************************************************
  // Engine shifts on LINK_CLK; bench or loopback supplies it
  csp_shifter #(
    .UNIT_BITS(CSP_UNIT_BITS)
  ) u_shifter (
    .link_clk(LINK_CLK),
    .rst(RST),
    .start_tgl(start_tgl_ff),
    .load_data(shreg_ff),
    .sin(two_wire ? SHARED_DATA_IN : SERIAL_INPUT_PIN),
    .sout(sout_link),
    .rx_data(rx_link),
    .done_tgl(done_tgl_link)
  );
  // Pin shows latch when idle, shifter bit while busy
  assign SERIAL_OUTPUT_LATCH = busy_ff ? sout_link : latch_ff;
  // Open drain: enable only when pulling low
  assign SHARED_DATA_OE_N = !(two_wire && !SERIAL_OUTPUT_LATCH);
  assign SERIAL_CLOCK_OUT = sck_ff;
  assign SERIAL_CLOCK_OE_N = !(enable && int_clk);
  assign TRANSFER_DONE = done_ff;
endmodule

/* hdl/csp_shifter.sv */
// Link-domain shift engine: eight bits, falling-edge shift, rising-edge sample.
`timescale 1ns/1ps
module csp_shifter
  import csp_pkg::*;
#(
  parameter int UNIT_BITS = CSP_UNIT_BITS
) (
  input wire logic link_clk,
  input wire logic rst,
  input wire logic start_tgl,
  input wire logic [7:0] load_data,
  input wire logic sin,
  output logic sout,
  output logic [7:0] rx_data,
  output logic done_tgl
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic [7:0] shift_ff;
  logic [3:0] cnt_ff;
  logic samp_ff;
  logic out_ff;
  logic done_ff;
  logic [7:0] rx_ff;
  wire start_evt = s2_ff ^ s3_ff;
  // ****************************************************************
  // Rising edge: sample input, detect start
  // ****************************************************************
  // Start toggle crosses with two flops; third detects its edge
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      samp_ff <= 1'b0;
    end else begin
      s1_ff <= start_tgl;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      samp_ff <= sin;
    end
  end
  // ****************************************************************
  // Falling edge: shift and stop after eight
  // ****************************************************************
  // Load happens on the falling edge after the start event
  always_ff @(negedge link_clk or posedge rst) begin
    if (rst) begin
      shift_ff <= 8'h00;
      cnt_ff <= 4'h0;
      out_ff <= 1'b1;
      done_ff <= 1'b0;
      rx_ff <= 8'h00;
    end else if (start_evt && cnt_ff == 4'h0) begin
      shift_ff <= {load_data[6:0], 1'b0};
      out_ff <= load_data[7];
      cnt_ff <= 4'h1;
    end else if (cnt_ff != 4'h0) begin
      shift_ff <= {shift_ff[6:0], samp_ff};
      out_ff <= shift_ff[7];
      if (cnt_ff == 4'(UNIT_BITS)) begin
        // Line idles high between units so no stale bit leaks into the next frame
        out_ff <= 1'b1;
        cnt_ff <= 4'h0;
        done_ff <= ~done_ff;
        rx_ff <= {shift_ff[6:0], samp_ff};
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
  assign sout = out_ff;
  assign rx_data = rx_ff;
  assign done_tgl = done_ff;
endmodule

/* verification/csp_peer.sv */
// Serial peer: echoes the inverse of each sampled bit on the next falling edge.
`timescale 1ns/1ps
module csp_peer (
  input wire logic link_clk,
  input wire logic rst,
  input wire logic sout,
  output logic sin
);
  logic last_ff;
  // Sample the port output on rises, as a peer receiver does
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      last_ff <= 1'b1;
    end else begin
      last_ff <= sout;
    end
  end
  // Drive on falls so the level is settled at the port's rising sample
  always_ff @(negedge link_clk or posedge rst) begin
    if (rst) begin
      sin <= 1'b0;
    end else begin
      sin <= ~last_ff;
    end
  end
endmodule

/* verification/csp_port_properties.sv */
// Checker of bus and serial relations at the ports of the clocked serial port.
`timescale 1ns/1ps
module csp_port_properties
  import csp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [15:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic SERIAL_OUTPUT_LATCH,
  input wire logic TRANSFER_DONE
);
  // ****************************************************************
  // Helper decode
  // ****************************************************************
  logic en_ff;
  wire take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wr_ctl = take & WB_WE_I & (WB_ADR_I == 16'hFF48) & en_ff;
  wire rd_shift = take & ~WB_WE_I & (WB_ADR_I == 16'hFF44);
  // Enable copy: triggers are ignored while the channel is off
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      en_ff <= 1'b0;
    end else if (take & WB_WE_I & (WB_ADR_I == 16'hFF40)) begin
      en_ff <= WB_DAT_I[7];
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_ack_after_take: assert property (take |=> WB_ACK_O)
    else $error("no ack after request");
  a_ack_single_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_upper_bytes_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  a_unmapped_reads_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[15:6] != 10'h3FD |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  a_trigger_reads_zero: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 16'hFF48 |-> WB_DAT_O == 32'h0)
    else $error("trigger bits read back set");
  a_release_sets_latch: assert property (wr_ctl && WB_DAT_I[0] |-> ##[1:3] SERIAL_OUTPUT_LATCH)
    else $error("release left latch low");
  a_command_clears_latch: assert property (wr_ctl && WB_DAT_I[1:0] == 2'h2 |-> ##[1:3] !SERIAL_OUTPUT_LATCH)
    else $error("command left latch high");
  a_read_clears_done: assert property (rd_shift |-> ##[1:3] !TRANSFER_DONE)
    else $error("done flag not cleared by read");
endmodule

bind csp_port csp_port_properties chk (.CLOCK(CLOCK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .SERIAL_OUTPUT_LATCH(SERIAL_OUTPUT_LATCH), .TRANSFER_DONE(TRANSFER_DONE));

/* verification/testbench.sv */
// Self-checking bench for the clocked serial port over Wishbone.
`timescale 1ns/1ps
module testbench
  import csp_pkg::*;
;
  logic CLOCK, RST, LINK_CLK, cyc, stb, we, ack, sin, sout, done, ckoe_n;
  logic [15:0] adr;
  logic [31:0] wdat, rdat, q;
  int num_errors, check_count;
  csp_port #(.DIV(1)) DUT (.CLOCK(CLOCK), .RST(RST), .LINK_CLK(LINK_CLK), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SERIAL_INPUT_PIN(sin), .SHARED_DATA_IN(1'b1), .SERIAL_OUTPUT_LATCH(sout), .SHARED_DATA_OE_N(),
    .SERIAL_CLOCK_OUT(), .SERIAL_CLOCK_OE_N(ckoe_n), .TRANSFER_DONE(done));
  csp_peer peer (.link_clk(LINK_CLK), .rst(RST), .sout(sout), .sin(sin));
  // ****************************************************************
  // Clocks, with the link clock offset in phase
  // ****************************************************************
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  initial begin
    LINK_CLK = 1'b0;
    #17;
    forever #62.5 LINK_CLK = ~LINK_CLK;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; held until ack is sampled high
  task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLOCK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge CLOCK);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      test_done;
    end
  endtask
  task rd(input logic [15:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      rev[i] = d[7 - i];
    end
  endfunction
  // One byte each way; the peer returns inverted bits one clock late
  task xfer(input logic lsb, input logic [7:0] d);
    logic [7:0] s, raw;
    int n;
    s = lsb ? rev(d) : d;
    raw = ~{1'b1, s[7:1]};
    wb(1'b1, 16'hFF48, 32'h1);
    wb(1'b1, 16'hFF44, {24'h0, d});
    rd(16'hFF4C, 32'h2);
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge CLOCK);
      n++;
    end
    chk(n < 400, 1);
    rd(16'hFF4C, 32'h1);
    rd(16'hFF44, {24'h0, lsb ? rev(raw) : raw});
    rd(16'hFF4C, 32'h0);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {cyc, stb, we, RST} = 4'h1;
    adr = 16'h0;
    wdat = 32'h0;
    num_errors = 0;
    check_count = 0;
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    rd(16'hFF40, {24'h0, CSP_MODE_RESET});
    rd(16'hFF48, {24'h0, CSP_BUS_CTRL_RESET});
    rd(16'hFF4C, 32'h0);
    chk(sout, 1);
    wb(1'b1, 16'hFF50, 32'hFF);
    rd(16'hFF50, 32'h0);
    $display("test reset and map done");
    wb(1'b1, 16'hFF44, 32'h5A);
    wb(1'b1, 16'hFF40, 32'h80);
    repeat (100) @(posedge CLOCK);
    rd(16'hFF4C, 32'h0);
    wb(1'b1, 16'hFF48, 32'h2);
    rd(16'hFF48, 32'h0);
    chk(sout, 0);
    wb(1'b1, 16'hFF48, 32'h1);
    rd(16'hFF48, 32'h0);
    chk(sout, 1);
    wb(1'b1, 16'hFF40, 32'h0);
    wb(1'b1, 16'hFF48, 32'h2);
    rd(16'hFF48, 32'h0);
    chk(sout, 1);
    wb(1'b1, 16'hFF40, 32'h88);
    rd(16'hFF40, 32'h88);
    chk(ckoe_n, 0);
    $display("test triggers and enable done");
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 16'hFF40, k[0] ? 32'h84 : 32'h80);
      xfer(k[0], k[1] ? 8'hB4 : 8'h1E);
    end
    $display("test transfers done");
    test_done;
  end
endmodule
